// ---- config_prom_pkg.sv ----
package config_prom_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CORE_CLK_HZ = 10_000_000;
	localparam int CORE_CLK_MHZ = CORE_CLK_HZ / 1_000_000;
	localparam int EXTRA_INIT_CLOCKS = 16;
	localparam int RECONF_PULSE_NS = 2000;
	localparam int RECONF_PULSE_CYCLES = (RECONF_PULSE_NS * CORE_CLK_MHZ + 999) / 1000;
	localparam int ERR_RESTART_NS = 10000;
	localparam int ERR_RESTART_CYCLES = (ERR_RESTART_NS * CORE_CLK_MHZ + 999) / 1000;
	localparam int SYNC_SETTLE_CYCLES = 2;
	localparam int CHAIN_TIMEOUT_CLOCKS = 1_000_000;

	// ****************************************
	// Sizes and reset values
	// ****************************************
	localparam int STORE_DEPTH_BITS = 1024;
	localparam int STORE_WORD_W = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int EDGE_CNT_W = 8;
	localparam logic CS_N_RESET = 1'b1;
	localparam logic LEVEL_LOW = 1'b0;

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [7:0] {
		ST_INIT = 8'h01,
		ST_HOLD = 8'h02,
		ST_SEND = 8'h04,
		ST_CHAIN = 8'h08,
		ST_EXTRA = 8'h10,
		ST_IDLE = 8'h20,
		ST_ERROR = 8'h40,
		ST_DONE = 8'h80
	} seq_state_type;

endpackage

// ---- word_stream_if.sv ----
`timescale 1ns/10ps
interface word_stream_if #(parameter int WIDTH = 8);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// ---- prom_word_fifo.sv ----
`timescale 1ns/10ps
module prom_word_fifo
	import config_prom_pkg::*;
#(
	parameter int WIDTH = STORE_WORD_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic flush_in,
	word_stream_if.snk fill_if,
	word_stream_if.src drain_if
);
	localparam int PW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
		$error("FIFO depth must be a power of two of at least two.");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [PW:0] count_r;
	logic [WIDTH-1:0] out_data_r;
	logic out_valid_r;

	wire push_w = fill_if.valid && fill_if.ready;
	wire load_w = (count_r != '0) && (!out_valid_r || drain_if.ready);
	wire [PW:0] count_nxt = count_r + (PW + 1)'(push_w) - (PW + 1)'(load_w);

	// Full counts only the array, so the output stage adds one word of slack.
	assign fill_if.ready = (count_r != (PW + 1)'(DEPTH));
	assign drain_if.valid = out_valid_r;
	assign drain_if.data = out_data_r;

	always_ff @(posedge core_clk_in) begin
		if (push_w) begin
			mem_r[wr_ptr_r] <= fill_if.data;
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
			out_valid_r <= 1'b0;
			out_data_r <= '0;
		end else if (flush_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
			out_valid_r <= 1'b0;
		end else begin
			wr_ptr_r <= wr_ptr_r + PW'(push_w);
			rd_ptr_r <= rd_ptr_r + PW'(load_w);
			count_r <= count_nxt;
			if (load_w) begin
				out_data_r <= mem_r[rd_ptr_r];
				out_valid_r <= 1'b1;
			end else if (drain_if.ready) begin
				out_valid_r <= 1'b0;
			end
		end
	end
endmodule

// ---- config_prom.sv ----
`timescale 1ns/10ps
// Operation
// - Cascade output low once address counter maxes.
// - Open-drain reconfiguration request pulled low by JTAG.
// - Chip select low at reset means master.
// - Master drives every serial clock pulse.
// - Master sends its own data first.
// - Master drops cascade after its last bit.
// - Master keeps clocking until targets finish.
// - Sixteen extra clocks after load complete.
// - Then zero-power idle, clock stopped.
// - Fault low on early or missing load complete.
// - Auto-restart after error when option set.
// - Rising clock advances only when enabled.
// - Enable low resets counter, stops clock low.
// - Data tri-stated before and after own data.
module config_prom
	import config_prom_pkg::*;
#(
	parameter int DEPTH_BITS = STORE_DEPTH_BITS,
	parameter int WORD_W = STORE_WORD_W,
	parameter int CHAIN_TIMEOUT = CHAIN_TIMEOUT_CLOCKS
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic serial_config_clock_in,
	input wire logic chip_select_n_in,
	input wire logic output_enable_in,
	input wire logic init_conf_cmd_in,
	input wire logic option_restart_in,
	input wire logic [WORD_W-1:0] store_word_in,
	output logic [$clog2(DEPTH_BITS / WORD_W)-1:0] store_addr_out,
	output logic serial_config_clock_out,
	output logic serial_config_clock_oe_out,
	output logic data_out,
	output logic data_oe_out,
	output logic cascade_out_n_out,
	output logic target_fault_n_out,
	output logic target_fault_n_oe_out,
	output logic reconfig_n_out,
	output logic reconfig_n_oe_out
);
	localparam int WORDS = DEPTH_BITS / WORD_W;
	localparam int AW = $clog2(DEPTH_BITS + 1);
	localparam int FW = $clog2(WORDS + 1);
	localparam int SA = $clog2(WORDS);
	localparam int BW = $clog2(WORD_W + 1);

	if (WORDS < 2 || WORDS * WORD_W != DEPTH_BITS) begin : g_chk
		$error("Stored depth must be a whole number of at least two words.");
	end

	function automatic logic [EDGE_CNT_W-1:0] gray_to_bin(input logic [EDGE_CNT_W-1:0] g);
		logic [EDGE_CNT_W-1:0] b;
		b = '0;
		for (int i = EDGE_CNT_W - 1; i >= 0; i--) begin
			b[i] = g[i] ^ ((i == EDGE_CNT_W - 1) ? 1'b0 : b[i + 1]);
		end
		return b;
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic cs_s1_r, cs_s2_r, oe_s1_r, oe_s2_r, jt_s1_r, jt_s2_r, jt_d_r;

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cs_s1_r <= CS_N_RESET;
			cs_s2_r <= CS_N_RESET;
			oe_s1_r <= 1'b0;
			oe_s2_r <= 1'b0;
			jt_s1_r <= 1'b0;
			jt_s2_r <= 1'b0;
			jt_d_r <= 1'b0;
		end else begin
			cs_s1_r <= chip_select_n_in;
			cs_s2_r <= cs_s1_r;
			oe_s1_r <= output_enable_in;
			oe_s2_r <= oe_s1_r;
			jt_s1_r <= init_conf_cmd_in;
			jt_s2_r <= jt_s1_r;
			jt_d_r <= jt_s2_r;
		end
	end

	// ****************************************
	// Link clock domain (slave role)
	// ****************************************
	// Edges are counted in gray code so a multi-bit count crosses safely.
	logic slave_en_r;
	logic len_s1_r, len_s2_r;
	logic [EDGE_CNT_W-1:0] edge_bin_r, edge_gray_r;
	wire [EDGE_CNT_W-1:0] edge_bin_nxt = edge_bin_r + EDGE_CNT_W'(1);

	always_ff @(posedge serial_config_clock_in or posedge reset_in) begin
		if (reset_in) begin
			len_s1_r <= 1'b0;
			len_s2_r <= 1'b0;
			edge_bin_r <= '0;
			edge_gray_r <= '0;
		end else begin
			len_s1_r <= slave_en_r;
			len_s2_r <= len_s1_r;
			if (len_s2_r) begin
				edge_bin_r <= edge_bin_nxt;
				edge_gray_r <= edge_bin_nxt ^ (edge_bin_nxt >> 1);
			end
		end
	end

	logic [EDGE_CNT_W-1:0] gray_s1_r, gray_s2_r, consumed_r;
	wire [EDGE_CNT_W-1:0] seen_w = gray_to_bin(gray_s2_r);
	wire pending_w = (seen_w != consumed_r);

	// ****************************************
	// Sequencer
	// ****************************************
	seq_state_type state_r, state_nxt;
	logic role_master_r;
	logic [1:0] init_wait_r;
	logic [AW-1:0] addr_r;
	logic [FW-1:0] fetch_addr_r;
	logic [BW-1:0] bits_left_r;
	logic [WORD_W-1:0] shift_r;
	logic serial_config_clock_r;
	logic [4:0] extra_cnt_r;
	logic [$clog2(CHAIN_TIMEOUT + 1)-1:0] chain_cnt_r;
	logic [$clog2(ERR_RESTART_CYCLES + 1)-1:0] err_cnt_r;
	logic [$clog2(RECONF_PULSE_CYCLES + 1)-1:0] reconf_cnt_r;
	logic clk_oe_r, data_r, data_oe_r, cascade_n_r, fault_oe_r, reconf_oe_r;
	logic drive_low_r;

	wire is_init = (state_r == ST_INIT);
	wire is_hold = (state_r == ST_HOLD);
	wire is_send = (state_r == ST_SEND);
	wire is_chain = (state_r == ST_CHAIN);
	wire is_extra = (state_r == ST_EXTRA);
	wire is_idle = (state_r == ST_IDLE);
	wire is_error = (state_r == ST_ERROR);
	wire exhausted_w = (addr_r == AW'(DEPTH_BITS));
	wire have_bit_w = (bits_left_r != '0);
	wire enabled_w = oe_s2_r && !cs_s2_r && !exhausted_w;
	wire flush_w = is_init || is_hold || is_error;
	wire err_done_w = (err_cnt_r == ($bits(err_cnt_r))'(ERR_RESTART_CYCLES - 1));

	word_stream_if #(.WIDTH(WORD_W)) fill_bus();
	word_stream_if #(.WIDTH(WORD_W)) drain_bus();

	prom_word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.flush_in(flush_w),
		.fill_if(fill_bus.snk),
		.drain_if(drain_bus.src)
	);

	assign fill_bus.valid = is_send && (fetch_addr_r != FW'(WORDS));
	assign fill_bus.data = store_word_in;
	wire pop_w = is_send && !have_bit_w && !exhausted_w && drain_bus.valid;
	assign drain_bus.ready = pop_w;

	// The master stalls its own clock rather than outrun the buffer.
	wire clk_run_w = role_master_r && oe_s2_r && ((is_send && have_bit_w) || is_chain || is_extra);
	wire serial_config_clock_nxt = clk_run_w ? !serial_config_clock_r : LEVEL_LOW;
	wire rise_w = clk_run_w && !serial_config_clock_r;
	wire slave_take_w = !role_master_r && pending_w && (have_bit_w || !is_send || !enabled_w);
	wire advance_w = is_send && enabled_w && have_bit_w
		&& (role_master_r ? rise_w : slave_take_w);

	wire [AW-1:0] addr_nxt = flush_w ? '0 : addr_r + AW'(advance_w);
	wire [WORD_W-1:0] shift_nxt = pop_w ? drain_bus.data
		: (advance_w ? (shift_r >> 1) : shift_r);
	wire [BW-1:0] bits_left_nxt = flush_w ? '0
		: (pop_w ? BW'(WORD_W) : bits_left_r - BW'(advance_w));
	wire jt_rise_w = jt_s2_r && !jt_d_r;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_INIT: begin
				if (init_wait_r == 2'(SYNC_SETTLE_CYCLES)) begin
					state_nxt = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (oe_s2_r) begin
					state_nxt = ST_SEND;
				end
			end
			ST_SEND: begin
				if (!oe_s2_r) begin
					state_nxt = ST_HOLD;
				end else if (role_master_r && cs_s2_r) begin
					state_nxt = ST_ERROR;
				end else if (exhausted_w) begin
					state_nxt = role_master_r ? ST_CHAIN : ST_DONE;
				end
			end
			ST_CHAIN: begin
				if (!oe_s2_r) begin
					state_nxt = ST_HOLD;
				end else if (cs_s2_r) begin
					state_nxt = ST_EXTRA;
				end else if (chain_cnt_r == ($bits(chain_cnt_r))'(CHAIN_TIMEOUT)) begin
					state_nxt = ST_ERROR;
				end
			end
			ST_EXTRA: begin
				if (!oe_s2_r) begin
					state_nxt = ST_HOLD;
				end else if (extra_cnt_r == 5'(EXTRA_INIT_CLOCKS)) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_ERROR: begin
				if (option_restart_in && err_done_w) begin
					state_nxt = ST_HOLD;
				end
			end
			ST_IDLE, ST_DONE: begin
				if (!oe_s2_r) begin
					state_nxt = ST_HOLD;
				end
			end
			default: begin
				state_nxt = ST_INIT;
			end
		endcase
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_r <= ST_INIT;
			init_wait_r <= '0;
			role_master_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (is_init) begin
				init_wait_r <= init_wait_r + 2'd1;
				role_master_r <= !cs_s2_r;
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			addr_r <= '0;
			fetch_addr_r <= '0;
			bits_left_r <= '0;
			shift_r <= '0;
			serial_config_clock_r <= LEVEL_LOW;
			consumed_r <= '0;
			gray_s1_r <= '0;
			gray_s2_r <= '0;
			slave_en_r <= 1'b0;
		end else begin
			addr_r <= addr_nxt;
			fetch_addr_r <= flush_w ? '0 : fetch_addr_r + FW'(fill_bus.valid && fill_bus.ready);
			bits_left_r <= bits_left_nxt;
			shift_r <= shift_nxt;
			serial_config_clock_r <= serial_config_clock_nxt;
			gray_s1_r <= edge_gray_r;
			gray_s2_r <= gray_s1_r;
			consumed_r <= consumed_r + EDGE_CNT_W'(slave_take_w);
			slave_en_r <= !role_master_r && (state_nxt == ST_SEND) && enabled_w;
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			extra_cnt_r <= '0;
			chain_cnt_r <= '0;
			err_cnt_r <= '0;
			reconf_cnt_r <= '0;
		end else begin
			extra_cnt_r <= is_extra ? extra_cnt_r + 5'(rise_w) : '0;
			chain_cnt_r <= is_chain ? chain_cnt_r + ($bits(chain_cnt_r))'(rise_w) : '0;
			err_cnt_r <= (is_error && !err_done_w) ? err_cnt_r + ($bits(err_cnt_r))'(1) : '0;
			if (jt_rise_w) begin
				reconf_cnt_r <= ($bits(reconf_cnt_r))'(RECONF_PULSE_CYCLES);
			end else if (reconf_cnt_r != '0) begin
				reconf_cnt_r <= reconf_cnt_r - ($bits(reconf_cnt_r))'(1);
			end
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			clk_oe_r <= 1'b0;
			data_r <= LEVEL_LOW;
			data_oe_r <= 1'b0;
			cascade_n_r <= 1'b1;
			fault_oe_r <= 1'b0;
			reconf_oe_r <= 1'b0;
			drive_low_r <= LEVEL_LOW;
		end else begin
			clk_oe_r <= role_master_r && !is_init;
			data_r <= shift_nxt[0];
			data_oe_r <= (state_nxt == ST_SEND) && enabled_w;
			cascade_n_r <= (addr_nxt != AW'(DEPTH_BITS));
			fault_oe_r <= (state_nxt == ST_ERROR);
			reconf_oe_r <= jt_rise_w || (reconf_cnt_r > ($bits(reconf_cnt_r))'(1));
			drive_low_r <= LEVEL_LOW;
		end
	end

	assign store_addr_out = fetch_addr_r[SA-1:0];
	assign serial_config_clock_out = serial_config_clock_r;
	assign serial_config_clock_oe_out = clk_oe_r;
	assign data_out = data_r;
	assign data_oe_out = data_oe_r;
	assign cascade_out_n_out = cascade_n_r;
	assign target_fault_n_out = drive_low_r;
	assign target_fault_n_oe_out = fault_oe_r;
	assign reconfig_n_out = drive_low_r;
	assign reconfig_n_oe_out = reconf_oe_r;

	// ****************************************
	// Checks
	// ****************************************
	property p_cascade_low;
		@(posedge core_clk_in) disable iff (reset_in)
		exhausted_w |-> !cascade_out_n_out;
	endproperty
	a_cascade_low: assert property (p_cascade_low) else $error("Cascade high after exhaustion.");

	property p_reconf_pulse;
		@(posedge core_clk_in) disable iff (reset_in)
		jt_rise_w |=> reconfig_n_oe_out [*8];
	endproperty
	a_reconf_pulse: assert property (p_reconf_pulse) else $error("Reconfiguration pulse short.");

	property p_master_drives;
		@(posedge core_clk_in) disable iff (reset_in)
		(role_master_r && is_send && $past(is_send)) |-> serial_config_clock_oe_out;
	endproperty
	a_master_drives: assert property (p_master_drives) else $error("Master not driving clock.");

	property p_slave_listens;
		@(posedge core_clk_in) disable iff (reset_in)
		!role_master_r |-> !serial_config_clock_oe_out;
	endproperty
	a_slave_listens: assert property (p_slave_listens) else $error("Slave drives clock.");

	property p_extra_count;
		@(posedge core_clk_in) disable iff (reset_in)
		$rose(is_idle) |-> $past(extra_cnt_r) == 5'(EXTRA_INIT_CLOCKS);
	endproperty
	a_extra_count: assert property (p_extra_count) else $error("Wrong extra clock count.");

	property p_idle_quiet;
		@(posedge core_clk_in) disable iff (reset_in)
		is_idle && $past(is_idle) |-> !serial_config_clock_out;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("Clock runs in idle.");

	property p_early_fault;
		@(posedge core_clk_in) disable iff (reset_in)
		(is_send && role_master_r && oe_s2_r && cs_s2_r) |=> target_fault_n_oe_out;
	endproperty
	a_early_fault: assert property (p_early_fault) else $error("No fault on early load end.");

	property p_restart;
		@(posedge core_clk_in) disable iff (reset_in)
		(is_error && option_restart_in && err_done_w) |=> is_hold ##1 (is_send || !$past(oe_s2_r));
	endproperty
	a_restart: assert property (p_restart) else $error("No restart after error.");

	property p_advance_gate;
		@(posedge core_clk_in) disable iff (reset_in)
		(addr_r != $past(addr_r) && addr_r != '0) |-> $past(oe_s2_r && !cs_s2_r);
	endproperty
	a_advance_gate: assert property (p_advance_gate) else $error("Counter moved while disabled.");

	property p_oe_reset;
		@(posedge core_clk_in) disable iff (reset_in)
		(!oe_s2_r && !is_init) |-> ##2 (addr_r == '0 && !serial_config_clock_out);
	endproperty
	a_oe_reset: assert property (p_oe_reset) else $error("Enable low did not reset.");

	property p_data_float;
		@(posedge core_clk_in) disable iff (reset_in)
		data_oe_out |-> $past(!cs_s2_r) && !$past(exhausted_w && !advance_w);
	endproperty
	a_data_float: assert property (p_data_float) else $error("Data driven out of turn.");
endmodule

// ---- target_model.sv ----
`timescale 1ns/10ps
// ****
// Target and slave chain model
// ****
module target_model #(parameter int NB = 64) (
	input wire logic clk_in,
	input wire logic clear_in,
	input wire logic [1:0] mode_in,
	input wire logic sclk_in,
	input wire logic data_in,
	input wire logic cascade_n_in,
	output logic done_out,
	output logic [NB-1:0] cap_out,
	output int nbits_out,
	output int extra_out
);
	logic sclk_q;
	logic held;
	logic casc_held;
	int chain;
	// Data and cascade are taken in the low phase, so a change at the rise cannot race.
	always @(posedge clk_in) begin
		sclk_q <= sclk_in;
		if (!sclk_in) begin
			held <= data_in;
			casc_held <= cascade_n_in;
		end
		if (clear_in) begin
			done_out <= 1'b0;
			nbits_out <= 0;
			extra_out <= 0;
			chain <= 0;
		end else begin
			if (sclk_in && !sclk_q) begin
				if (done_out) begin
					extra_out <= extra_out + 1;
				end else if (!casc_held) begin
					chain <= chain + 1;
				end else begin
					cap_out[nbits_out] <= held;
					nbits_out <= nbits_out + 1;
				end
			end
			// Mode 1 ends the load early, mode 2 never ends it.
			if ((mode_in == 2'h1 && nbits_out >= 8) || (mode_in == 2'h0 && chain >= 3)) begin
				done_out <= 1'b1;
			end
		end
	end
endmodule

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
	import config_prom_pkg::*;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic link_clk = 1'b0;
	logic link_en = 1'b0;
	logic tb_cs_n = 1'b0;
	logic oe = 1'b0;
	logic cmd = 1'b0;
	logic opt = 1'b0;
	logic clear = 1'b1;
	logic [1:0] mode = 2'h0;
	logic [2:0] addr;
	logic sclk_out, sclk_oe, data, data_oe, casc_n, fault_n, fault_oe, reconf_n, reconf_oe;
	logic sclk_w, data_w, done;
	logic [63:0] cap;
	int nbits, extra;
	int errors = 0;
	int n_checks = 0;
	initial begin
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		#17;
		forever #32 link_clk = ~link_clk;
	end
	// Clock and data are shared wires, chip select comes from the load-complete line.
	assign sclk_w = sclk_oe ? sclk_out : (link_en & link_clk);
	assign data_w = data_oe ? data : ~data;
	config_prom #(.DEPTH_BITS(64), .WORD_W(8), .CHAIN_TIMEOUT(200)) u_config_prom (
		.core_clk_in(core_clk), .reset_in(reset), .serial_config_clock_in(sclk_w),
		.chip_select_n_in(tb_cs_n | done), .output_enable_in(oe),
		.init_conf_cmd_in(cmd), .option_restart_in(opt), .store_word_in(word(addr)),
		.store_addr_out(addr), .serial_config_clock_out(sclk_out),
		.serial_config_clock_oe_out(sclk_oe), .data_out(data), .data_oe_out(data_oe),
		.cascade_out_n_out(casc_n), .target_fault_n_out(fault_n),
		.target_fault_n_oe_out(fault_oe), .reconfig_n_out(reconf_n),
		.reconfig_n_oe_out(reconf_oe));
	// The reconfiguration line of this single memory is checked here only; the target model has no input for it.
	target_model #(.NB(64)) u_target_model (.clk_in(core_clk), .clear_in(clear),
		.mode_in(mode), .sclk_in(sclk_w), .data_in(data_w), .cascade_n_in(casc_n),
		.done_out(done), .cap_out(cap), .nbits_out(nbits), .extra_out(extra));
	// ****
	// Helpers
	// ****
	function automatic logic [7:0] word(logic [2:0] a);
		return {a, ~a, a[1:0]} ^ 8'hA5;
	endfunction
	function automatic logic [63:0] exp_stream();
		logic [63:0] e;
		logic [7:0] w;
		for (int i = 0; i < 64; i++) begin
			w = word(3'(i / 8));
			e[i] = w[i % 8];
		end
		return e;
	endfunction
	function automatic logic sel(int w);
		case (w)
			0: return casc_n === 1'b0;
			1: return fault_oe === 1'b1;
			2: return fault_oe === 1'b0;
			3: return data_oe === 1'b1;
			4: return reconf_oe === 1'b1;
			default: return done === 1'b1;
		endcase
	endfunction
	task automatic stop_test();
		$display("errors=%0d n_checks=%0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	task automatic wait_on(input int w, input int lim);
		for (int i = 0; i < lim && !sel(w); i++) begin
			@(negedge core_clk);
		end
		check("wait_done", 1, sel(w));
		if (!sel(w)) begin
			stop_test();
		end
	endtask
	task automatic reset_dut(input logic cs, input logic [1:0] md, input logic op);
		@(posedge core_clk);
		reset <= 1'b1;
		tb_cs_n <= cs;
		oe <= 1'b0;
		clear <= 1'b1;
		mode <= md;
		opt <= op;
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		clear <= 1'b0;
		repeat (4) @(posedge core_clk);
		oe <= 1'b1;
	endtask
	task automatic stream_ok();
		wait_on(0, 400);
		repeat (2) @(negedge core_clk);
		check("stream", exp_stream(), cap);
		check("bits", 64, nbits);
		check("data_oe_end", 0, data_oe);
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_full();
		reset_dut(1'b0, 2'h0, 1'b0);
		stream_ok();
		wait_on(5, 50);
		repeat (80) @(negedge core_clk);
		// Rises during the three edges of the chip select synchroniser come on top of the sixteen.
		check("extra_rises", 1, extra >= EXTRA_INIT_CLOCKS + 1
			&& extra <= EXTRA_INIT_CLOCKS + 2);
		check("clk_idle", 0, sclk_out);
		check("fault_none", 0, fault_oe);
	endtask
	task automatic t_restart();
		reset_dut(1'b0, 2'h1, 1'b1);
		wait_on(1, 200);
		@(posedge core_clk);
		clear <= 1'b1;
		mode <= 2'h0;
		@(posedge core_clk);
		clear <= 1'b0;
		repeat (85) @(negedge core_clk);
		check("fault_held", 1, fault_oe);
		wait_on(2, 40);
		stream_ok();
	endtask
	task automatic t_timeout();
		reset_dut(1'b0, 2'h2, 1'b0);
		wait_on(1, 800);
		repeat (150) @(negedge core_clk);
		check("fault_stays", 1, fault_oe);
		check("fault_level", 0, fault_n);
	endtask
	task automatic t_oe_low();
		int n;
		reset_dut(1'b0, 2'h0, 1'b0);
		wait_on(3, 50);
		repeat (20) @(posedge core_clk);
		oe <= 1'b0;
		repeat (6) @(negedge core_clk);
		n = nbits;
		check("clk_low", 0, sclk_out);
		check("data_float", 0, data_oe);
		repeat (20) @(negedge core_clk);
		check("no_advance", n, nbits);
	endtask
	task automatic t_reconf();
		int n;
		n = 0;
		@(posedge core_clk);
		cmd <= 1'b1;
		repeat (3) @(posedge core_clk);
		cmd <= 1'b0;
		wait_on(4, 10);
		while (reconf_oe === 1'b1 && n < 40) begin
			n++;
			@(negedge core_clk);
		end
		check("reconf_len", 20, n);
		if (n >= 40) begin
			stop_test();
		end
		check("reconf_level", 0, reconf_n);
	endtask
	task automatic t_slave();
		reset_dut(1'b1, 2'h2, 1'b0);
		repeat (30) @(negedge core_clk);
		check("slave_clk_oe", 0, sclk_oe);
		check("slave_float", 0, data_oe);
		@(posedge core_clk);
		tb_cs_n <= 1'b0;
		@(negedge link_clk);
		link_en = 1'b1;
		wait_on(3, 30);
		repeat (60) @(negedge core_clk);
		@(negedge link_clk);
		link_en = 1'b0;
		wait_on(0, 300);
		repeat (8) @(negedge core_clk);
		check("slave_end_float", 0, data_oe);
		check("slave_clk_in", 0, sclk_oe);
	endtask
	initial begin
		t_full();
		t_restart();
		t_timeout();
		t_oe_low();
		t_reconf();
		t_slave();
		stop_test();
	end
endmodule
